/* File: rtl/access_rule_entry.sv */
// Operation
// - IPv4 criteria apply only for IPv4 selection
// - Protocol any ignores protocol field
// - Specific protocol needs equal 8-bit value
// - ICMP selection: ICMP frames, type/code checked
// - UDP selection: UDP frames, UDP criteria checked
// - TCP selection: TCP frames, TCP criteria checked
// - TTL zero: frames with TTL above zero miss
// - TTL non-zero: hit needs TTL above zero
// - Fragment no: fragmented frames miss
// - Fragment yes: hit needs fragmented frame
// - Options no: frames with options miss
// - Options yes: hit needs options present
// - Any makes TTL, fragment, options irrelevant
// - Source any ignores source address
// - Source host needs exact address equality
// - Source network compares masked bits
// - Destination any ignores destination address
// - Destination host needs exact address equality
// - Destination network compares masked bits
// - ICMP type any or equal value
// - ICMP code specific needs equal value
// - ICMP code any ignores code
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module access_rule_entry (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire acl_entry_pkg::reg_req_t reg_req,
	output logic [31:0] reg_rdata,
	input wire acl_entry_pkg::frame_t frame,
	output logic result_valid,
	output logic hit,
	output logic miss
);

	acl_entry_pkg::state_t state;
	acl_entry_pkg::state_t next_state;

	// Three-way header condition check
	function automatic logic tri_ok(input acl_entry_pkg::tri_mode_t mode, input logic cond);
		case (mode)
			acl_entry_pkg::TRI_ANY: tri_ok = 1'b1;
			acl_entry_pkg::TRI_NO: tri_ok = !cond;
			acl_entry_pkg::TRI_YES: tri_ok = cond;
			default: tri_ok = 1'b0;
		endcase
	endfunction : tri_ok

	// Address criterion check
	function automatic logic addr_ok(
		input acl_entry_pkg::addr_mode_t mode,
		input logic [31:0] value,
		input logic [31:0] cfg_addr,
		input logic [31:0] cfg_mask
	);
		case (mode)
			acl_entry_pkg::ADDR_ANY: addr_ok = 1'b1;
			acl_entry_pkg::ADDR_HOST: addr_ok = (value == cfg_addr);
			acl_entry_pkg::ADDR_NETWORK: addr_ok = ((value & cfg_mask) == (cfg_addr & cfg_mask));
			default: addr_ok = 1'b0;
		endcase
	endfunction : addr_ok

	// Byte criterion check: any or equal
	function automatic logic byte_ok(input logic specific, input logic [7:0] value, input logic [7:0] cfg_val);
		byte_ok = !specific || (value == cfg_val);
	endfunction : byte_ok

	logic proto_ok;
	logic icmp_ok;
	logic ttl_ok;
	logic frag_ok;
	logic opt_ok;
	logic src_ok;
	logic dst_ok;
	logic ipv4_ok;
	logic entry_hit;
	logic is_fragment;
	logic has_options;
	logic [31:0] rd_value;

	always_comb
	begin
		is_fragment = frame.more_frag || (frame.frag_offset != acl_entry_pkg::FRAG_OFS_ZERO);
		has_options = frame.ihl > acl_entry_pkg::IHL_NO_OPTIONS;
		icmp_ok = byte_ok(state.cfg.icmp_type_spec, frame.icmp_type, state.cfg.icmp_type_val)
			&& byte_ok(state.cfg.icmp_code_spec, frame.icmp_code, state.cfg.icmp_code_val);
		case (state.cfg.proto_mode)
			acl_entry_pkg::PROTO_ANY: proto_ok = 1'b1;
			acl_entry_pkg::PROTO_SPECIFIC: proto_ok = (frame.protocol == state.cfg.proto_value);
			acl_entry_pkg::PROTO_ICMP: proto_ok = (frame.protocol == acl_entry_pkg::IP_PROTO_ICMP) && icmp_ok;
			acl_entry_pkg::PROTO_UDP: proto_ok = (frame.protocol == acl_entry_pkg::IP_PROTO_UDP) && frame.l4_ok;
			acl_entry_pkg::PROTO_TCP: proto_ok = (frame.protocol == acl_entry_pkg::IP_PROTO_TCP) && frame.l4_ok;
			default: proto_ok = 1'b0;
		endcase
		ttl_ok = tri_ok(state.cfg.ttl_mode, frame.ttl != acl_entry_pkg::TTL_ZERO);
		frag_ok = tri_ok(state.cfg.frag_mode, is_fragment);
		opt_ok = tri_ok(state.cfg.opt_mode, has_options);
		src_ok = addr_ok(state.cfg.source_ip_criterion, frame.src_addr,
			state.cfg.src_addr, state.cfg.src_mask);
		dst_ok = addr_ok(state.cfg.destination_ip_criterion, frame.dst_addr,
			state.cfg.dst_addr, state.cfg.dst_mask);
		// Other frame types leave these settings without effect
		if (state.cfg.frame_type == acl_entry_pkg::FT_IPV4)
		begin
			ipv4_ok = frame.is_ipv4 && proto_ok && ttl_ok && frag_ok && opt_ok && src_ok && dst_ok;
		end
		else
		begin
			ipv4_ok = 1'b1;
		end
		entry_hit = state.cfg.enable && ipv4_ok;
	end

	// Register read mux
	always_comb
	begin
		rd_value = acl_entry_pkg::RD_ZERO;
		case (reg_req.addr)
			acl_entry_pkg::OFS_CONTROL:
			begin
				rd_value[acl_entry_pkg::CTL_ENABLE_BIT] = state.cfg.enable;
				rd_value[acl_entry_pkg::CTL_FTYPE_LSB +: 2] = state.cfg.frame_type;
			end
			acl_entry_pkg::OFS_PROTOCOL:
			begin
				rd_value[acl_entry_pkg::PRO_MODE_LSB +: 3] = state.cfg.proto_mode;
				rd_value[acl_entry_pkg::PRO_VALUE_LSB +: 8] = state.cfg.proto_value;
			end
			acl_entry_pkg::OFS_HEADER:
			begin
				rd_value[acl_entry_pkg::HDR_TTL_LSB +: 2] = state.cfg.ttl_mode;
				rd_value[acl_entry_pkg::HDR_FRAG_LSB +: 2] = state.cfg.frag_mode;
				rd_value[acl_entry_pkg::HDR_OPT_LSB +: 2] = state.cfg.opt_mode;
			end
			acl_entry_pkg::OFS_ADDR_MODE:
			begin
				rd_value[acl_entry_pkg::AM_SRC_LSB +: 2] = state.cfg.source_ip_criterion;
				rd_value[acl_entry_pkg::AM_DST_LSB +: 2] = state.cfg.destination_ip_criterion;
			end
			acl_entry_pkg::OFS_SRC_ADDR: rd_value = state.cfg.src_addr;
			acl_entry_pkg::OFS_SRC_MASK: rd_value = state.cfg.src_mask;
			acl_entry_pkg::OFS_DST_ADDR: rd_value = state.cfg.dst_addr;
			acl_entry_pkg::OFS_DST_MASK: rd_value = state.cfg.dst_mask;
			acl_entry_pkg::OFS_ICMP:
			begin
				rd_value[acl_entry_pkg::ICMP_TYPE_SPEC_BIT] = state.cfg.icmp_type_spec;
				rd_value[acl_entry_pkg::ICMP_CODE_SPEC_BIT] = state.cfg.icmp_code_spec;
				rd_value[acl_entry_pkg::ICMP_TYPE_LSB +: 8] = state.cfg.icmp_type_val;
				rd_value[acl_entry_pkg::ICMP_CODE_LSB +: 8] = state.cfg.icmp_code_val;
			end
			acl_entry_pkg::OFS_STATUS:
			begin
				rd_value[acl_entry_pkg::ST_HIT_BIT] = state.last_hit;
				rd_value[acl_entry_pkg::ST_SEEN_BIT] = state.seen;
			end
			acl_entry_pkg::OFS_HIT_COUNT: rd_value = state.hit_count;
			acl_entry_pkg::OFS_MISS_COUNT: rd_value = state.miss_count;
			default: rd_value = acl_entry_pkg::RD_ZERO;
		endcase
	end

	// Next state
	always_comb
	begin
		next_state = state;
		next_state.rd_data = reg_req.re ? rd_value : acl_entry_pkg::RD_ZERO;
		if (reg_req.we)
		begin
			case (reg_req.addr)
				acl_entry_pkg::OFS_CONTROL:
				begin
					next_state.cfg.enable = reg_req.wdata[acl_entry_pkg::CTL_ENABLE_BIT];
					next_state.cfg.frame_type =
						acl_entry_pkg::frame_type_t'(reg_req.wdata[acl_entry_pkg::CTL_FTYPE_LSB +: 2]);
				end
				acl_entry_pkg::OFS_PROTOCOL:
				begin
					next_state.cfg.proto_mode =
						acl_entry_pkg::proto_mode_t'(reg_req.wdata[acl_entry_pkg::PRO_MODE_LSB +: 3]);
					next_state.cfg.proto_value = reg_req.wdata[acl_entry_pkg::PRO_VALUE_LSB +: 8];
				end
				acl_entry_pkg::OFS_HEADER:
				begin
					next_state.cfg.ttl_mode =
						acl_entry_pkg::tri_mode_t'(reg_req.wdata[acl_entry_pkg::HDR_TTL_LSB +: 2]);
					next_state.cfg.frag_mode =
						acl_entry_pkg::tri_mode_t'(reg_req.wdata[acl_entry_pkg::HDR_FRAG_LSB +: 2]);
					next_state.cfg.opt_mode =
						acl_entry_pkg::tri_mode_t'(reg_req.wdata[acl_entry_pkg::HDR_OPT_LSB +: 2]);
				end
				acl_entry_pkg::OFS_ADDR_MODE:
				begin
					next_state.cfg.source_ip_criterion =
						acl_entry_pkg::addr_mode_t'(reg_req.wdata[acl_entry_pkg::AM_SRC_LSB +: 2]);
					next_state.cfg.destination_ip_criterion =
						acl_entry_pkg::addr_mode_t'(reg_req.wdata[acl_entry_pkg::AM_DST_LSB +: 2]);
				end
				acl_entry_pkg::OFS_SRC_ADDR: next_state.cfg.src_addr = reg_req.wdata;
				acl_entry_pkg::OFS_SRC_MASK: next_state.cfg.src_mask = reg_req.wdata;
				acl_entry_pkg::OFS_DST_ADDR: next_state.cfg.dst_addr = reg_req.wdata;
				acl_entry_pkg::OFS_DST_MASK: next_state.cfg.dst_mask = reg_req.wdata;
				acl_entry_pkg::OFS_ICMP:
				begin
					next_state.cfg.icmp_type_spec = reg_req.wdata[acl_entry_pkg::ICMP_TYPE_SPEC_BIT];
					next_state.cfg.icmp_code_spec = reg_req.wdata[acl_entry_pkg::ICMP_CODE_SPEC_BIT];
					next_state.cfg.icmp_type_val = reg_req.wdata[acl_entry_pkg::ICMP_TYPE_LSB +: 8];
					next_state.cfg.icmp_code_val = reg_req.wdata[acl_entry_pkg::ICMP_CODE_LSB +: 8];
				end
				acl_entry_pkg::OFS_HIT_COUNT: next_state.hit_count = acl_entry_pkg::COUNT_RESET;
				acl_entry_pkg::OFS_MISS_COUNT: next_state.miss_count = acl_entry_pkg::COUNT_RESET;
				default: next_state.seen = state.seen;
			endcase
		end
		// Match result, one cycle after the frame
		next_state.result_valid = frame.valid;
		next_state.hit = frame.valid && entry_hit;
		next_state.miss = frame.valid && !entry_hit;
		if (frame.valid)
		begin
			next_state.last_hit = entry_hit;
			next_state.seen = 1'b1;
			// Count after a clear in the same cycle
			if (entry_hit)
			begin
				next_state.hit_count = next_state.hit_count + acl_entry_pkg::COUNT_ONE;
			end
			else
			begin
				next_state.miss_count = next_state.miss_count + acl_entry_pkg::COUNT_ONE;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= '0;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign reg_rdata = state.rd_data;
	assign result_valid = state.result_valid;
	assign hit = state.hit;
	assign miss = state.miss;

endmodule : access_rule_entry

/* File: rtl/acl_entry_pkg.sv */
package acl_entry_pkg;

	localparam int REG_AW = 8;
	localparam int REG_DW = 32;

	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_PROTOCOL = 8'h04;
	localparam logic [7:0] OFS_HEADER = 8'h08;
	localparam logic [7:0] OFS_ADDR_MODE = 8'h0c;
	localparam logic [7:0] OFS_SRC_ADDR = 8'h10;
	localparam logic [7:0] OFS_SRC_MASK = 8'h14;
	localparam logic [7:0] OFS_DST_ADDR = 8'h18;
	localparam logic [7:0] OFS_DST_MASK = 8'h1c;
	localparam logic [7:0] OFS_ICMP = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] OFS_HIT_COUNT = 8'h28;
	localparam logic [7:0] OFS_MISS_COUNT = 8'h2c;

	// Field positions
	localparam int CTL_ENABLE_BIT = 0;
	localparam int CTL_FTYPE_LSB = 4;
	localparam int PRO_MODE_LSB = 0;
	localparam int PRO_VALUE_LSB = 8;
	localparam int HDR_TTL_LSB = 0;
	localparam int HDR_FRAG_LSB = 2;
	localparam int HDR_OPT_LSB = 4;
	localparam int AM_SRC_LSB = 0;
	localparam int AM_DST_LSB = 2;
	localparam int ICMP_TYPE_SPEC_BIT = 0;
	localparam int ICMP_CODE_SPEC_BIT = 1;
	localparam int ICMP_TYPE_LSB = 8;
	localparam int ICMP_CODE_LSB = 16;
	localparam int ST_HIT_BIT = 0;
	localparam int ST_SEEN_BIT = 1;

	// Header, counter and read-data constants
	localparam logic [7:0] IP_PROTO_ICMP = 8'h01;
	localparam logic [7:0] IP_PROTO_TCP = 8'h06;
	localparam logic [7:0] IP_PROTO_UDP = 8'h11;
	localparam logic [3:0] IHL_NO_OPTIONS = 4'h5;
	localparam logic [7:0] TTL_ZERO = 8'h00;
	localparam logic [12:0] FRAG_OFS_ZERO = 13'h0000;
	localparam logic [31:0] COUNT_ONE = 32'h00000001;
	localparam logic [31:0] COUNT_RESET = 32'h00000000;
	localparam logic [31:0] RD_ZERO = 32'h00000000;

	typedef enum logic [1:0] {
		FT_ANY = 2'h0,
		FT_ETHERTYPE = 2'h1,
		FT_ARP = 2'h2,
		FT_IPV4 = 2'h3
	} frame_type_t;

	typedef enum logic [2:0] {
		PROTO_ANY = 3'h0,
		PROTO_SPECIFIC = 3'h1,
		PROTO_ICMP = 3'h2,
		PROTO_UDP = 3'h3,
		PROTO_TCP = 3'h4
	} proto_mode_t;

	// For time-to-live: NO means zero, YES means non-zero
	typedef enum logic [1:0] {
		TRI_ANY = 2'h0,
		TRI_NO = 2'h1,
		TRI_YES = 2'h2
	} tri_mode_t;

	typedef enum logic [1:0] {
		ADDR_ANY = 2'h0,
		ADDR_HOST = 2'h1,
		ADDR_NETWORK = 2'h2
	} addr_mode_t;

	typedef struct packed {
		logic valid;
		logic is_ipv4;
		logic [7:0] protocol;
		logic [7:0] ttl;
		logic more_frag;
		logic [12:0] frag_offset;
		logic [3:0] ihl;
		logic [31:0] src_addr;
		logic [31:0] dst_addr;
		logic [7:0] icmp_type;
		logic [7:0] icmp_code;
		logic l4_ok;
	} frame_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic we;
		logic re;
	} reg_req_t;

	typedef struct packed {
		logic enable;
		frame_type_t frame_type;
		proto_mode_t proto_mode;
		logic [7:0] proto_value;
		tri_mode_t ttl_mode;
		tri_mode_t frag_mode;
		tri_mode_t opt_mode;
		addr_mode_t source_ip_criterion;
		addr_mode_t destination_ip_criterion;
		logic [31:0] src_addr;
		logic [31:0] src_mask;
		logic [31:0] dst_addr;
		logic [31:0] dst_mask;
		logic icmp_type_spec;
		logic icmp_code_spec;
		logic [7:0] icmp_type_val;
		logic [7:0] icmp_code_val;
	} cfg_t;

	typedef struct packed {
		cfg_t cfg;
		logic [31:0] rd_data;
		logic result_valid;
		logic hit;
		logic miss;
		logic last_hit;
		logic seen;
		logic [31:0] hit_count;
		logic [31:0] miss_count;
	} state_t;

endpackage : acl_entry_pkg

/* File: tb/frame_src.sv */
`timescale 1ns/1ps
module frame_src (
	input wire logic clk_sys,
	input wire logic req,
	input wire acl_entry_pkg::frame_t req_frame,
	output acl_entry_pkg::frame_t frame
);
	acl_entry_pkg::frame_t idle;
	initial frame = '0;
	// Idle fields flip every cycle so stale headers are never trusted
	always @(posedge clk_sys)
	begin
		idle = ~frame;
		idle.valid = 1'b0;
		if (req)
			frame <= req_frame;
		else
			frame <= idle;
	end
endmodule : frame_src

/* File: tb/acl_chk.sv */
`timescale 1ns/1ps
module acl_chk (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire acl_entry_pkg::reg_req_t reg_req,
	input wire logic [31:0] reg_rdata,
	input wire acl_entry_pkg::frame_t frame,
	input wire logic result_valid,
	input wire logic hit,
	input wire logic miss
);
	logic [5:0] ctl;
	logic [15:0] pro;
	logic [5:0] hdr;
	logic on4;
	// Shadow of the control, protocol and header configuration seen on the bus
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			ctl <= 6'h00;
			pro <= 16'h0000;
			hdr <= 6'h00;
		end
		else if (reg_req.we)
		begin
			if (reg_req.addr == acl_entry_pkg::OFS_CONTROL) ctl <= reg_req.wdata[5:0];
			if (reg_req.addr == acl_entry_pkg::OFS_PROTOCOL) pro <= reg_req.wdata[15:0];
			if (reg_req.addr == acl_entry_pkg::OFS_HEADER) hdr <= reg_req.wdata[5:0];
		end
	end
	assign on4 = frame.valid && ctl[0] && ctl[5:4] == 2'h3 && frame.is_ipv4;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_result_one_way: assert property (frame.valid |=> result_valid && (hit ^ miss))
		else $error("frame result missing or ambiguous");
	a_no_spurious: assert property (!frame.valid |=> !result_valid && !hit && !miss)
		else $error("result without frame");
	a_other_type: assert property (frame.valid && ctl[0] && ctl[5:4] != 2'h3 |=> hit)
		else $error("non ipv4 selection did not hit");
	a_proto_value: assert property (on4 && pro[2:0] == 3'h1 && frame.protocol != pro[15:8] |=> miss)
		else $error("protocol mismatch hit");
	a_proto_named: assert property (on4 && ((pro[2:0] == 3'h2 && frame.protocol != 8'h01)
		|| (pro[2:0] == 3'h3 && frame.protocol != 8'h11) || (pro[2:0] == 3'h4 && frame.protocol != 8'h06))
		|=> miss)
		else $error("wrong transport hit");
	a_l4_fail: assert property (on4 && pro[2:0] inside {3'h3, 3'h4} && !frame.l4_ok |=> miss)
		else $error("transport criteria ignored");
	a_ttl_zero: assert property (on4 && hdr[1:0] == 2'h1 && frame.ttl != 8'h00 |=> miss)
		else $error("ttl zero mode hit");
	a_ttl_live: assert property (on4 && hdr[1:0] == 2'h2 && frame.ttl == 8'h00 |=> miss)
		else $error("ttl non zero mode hit");
	a_frag_no: assert property (on4 && hdr[3:2] == 2'h1 &&
		(frame.more_frag || frame.frag_offset != 13'h0000) |=> miss)
		else $error("fragment hit");
	a_opt_no: assert property (on4 && hdr[5:4] == 2'h1 && frame.ihl > 4'h5 |=> miss)
		else $error("options hit");
	a_rd_idle: assert property (!reg_req.re |=> reg_rdata == 32'h00000000)
		else $error("read data outside read");
	a_rd_ctl: assert property (reg_req.re && reg_req.addr == acl_entry_pkg::OFS_CONTROL
		|=> reg_rdata == {26'h0000000, ctl[5:4], 3'h0, ctl[0]})
		else $error("control readback wrong");
	c_hit: cover property (result_valid && hit);
	c_miss: cover property (result_valid && miss);
	c_back: cover property (frame.valid ##1 frame.valid);
endmodule : acl_chk
bind access_rule_entry acl_chk chk (.clk_sys(clk_sys), .resetn(resetn), .reg_req(reg_req),
	.reg_rdata(reg_rdata), .frame(frame), .result_valid(result_valid), .hit(hit), .miss(miss));

/* File: tb/tb_ipv4_acl_entry_matcher.sv */
`timescale 1ns/1ps
module tb_ipv4_acl_entry_matcher;
	typedef struct packed {
		logic [15:0] pro;
		logic [7:0] hdr;
		logic [3:0] am;
		logic [23:0] icmp;
		logic [7:0] proto;
		logic [7:0] ttl;
		logic [3:0] fr;
		logic [3:0] ihl;
		logic [15:0] s;
		logic [15:0] d;
		logic [3:0] le;
	} row_t;
	row_t rows [39] = '{
		112'h0000000000000_0108050001a8003, 112'h0000000000000_ff08050001a8003, 112'h1101000000000_1108050001a8003,
		112'h1101000000000_1008050001a8002, 112'h0001000000000_0008050001a8003, 112'hff01000000000_ff08050001a8003,
		112'h0002000000801_0108050001a8003, 112'h0002000000801_0608050001a8002, 112'h0002000000901_0108050001a8002,
		112'h0002000000002_0108050001a8003, 112'h0002000030002_0108050001a8002, 112'h0002000030000_0108050001a8003,
		112'h0003000000000_1108050001a8003, 112'h0003000000000_1108050001a8000, 112'h0003000000000_0608050001a8002,
		112'h0004000000000_0608050001a8003, 112'h0004000000000_0608050001a8000, 112'h0004000000000_1108050001a8002,
		112'h0000010000000_0108050001a8002, 112'h0000010000000_0100050001a8003, 112'h0000020000000_0100050001a8002,
		112'h0000020000000_0101050001a8003, 112'h0000040000000_0108250001a8002, 112'h0000040000000_0108150001a8002,
		112'h0000080000000_0108050001a8002, 112'h0000080000000_0108150001a8003, 112'h0000100000000_0108060001a8002,
		112'h0000200000000_0108050001a8002, 112'h0000200000000_01080f0001a8003, 112'h0000000000000_01003f0001a8003,
		112'h0000001000000_0108050002a8002, 112'h0000002000000_0108050002a8003, 112'h0000002000000_0108050101a8002,
		112'h0000000000000_0108050101a8003, 112'h0000004000000_0108050001a8ff2, 112'h0000008000000_0108050001a8ff3,
		112'h0000008000000_0108050001a9002, 112'h000202a000801_0108050002a8ff3, 112'h000202a000801_0100050002a8ff2};
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	acl_entry_pkg::reg_req_t rq = '0;
	logic [31:0] reg_rdata;
	acl_entry_pkg::frame_t frame;
	acl_entry_pkg::frame_t rf = '0;
	acl_entry_pkg::frame_t f;
	row_t r;
	logic req = 1'b0;
	logic result_valid;
	logic hit;
	logic miss;
	int err_count = 0;
	int num_checks = 0;
	always #2 clk_sys = ~clk_sys;
	frame_src src (.clk_sys(clk_sys), .req(req), .req_frame(rf), .frame(frame));
	access_rule_entry dut (.clk_sys(clk_sys), .resetn(resetn), .reg_req(rq), .reg_rdata(reg_rdata),
		.frame(frame), .result_valid(result_valid), .hit(hit), .miss(miss));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
			err_count++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		rq <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		rq.we <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge clk_sys);
		rq <= '{a, 32'h00000000, 1'b0, 1'b1};
		@(posedge clk_sys);
		rq.re <= 1'b0;
		#1;
		chk(nm, e, reg_rdata);
	endtask : rd
	task automatic send(input acl_entry_pkg::frame_t fr, input logic e);
		@(posedge clk_sys);
		req <= 1'b1;
		rf <= fr;
		@(posedge clk_sys);
		req <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk("result_valid", 32'h1, {31'h0, result_valid});
		chk("hit", {31'h0, e}, {31'h0, hit});
		chk("miss", {31'h0, !e}, {31'h0, miss});
	endtask : send
	function automatic acl_entry_pkg::frame_t mk(input row_t r);
		acl_entry_pkg::frame_t x;
		x = '0;
		x.valid = 1'b1;
		x.is_ipv4 = 1'b1;
		x.protocol = r.proto;
		x.ttl = r.ttl;
		x.more_frag = r.fr[1];
		x.frag_offset = {12'h000, r.fr[0]};
		x.ihl = r.ihl;
		x.src_addr = {16'h0a00, r.s};
		x.dst_addr = {8'hc0, r.d, 8'h05};
		x.icmp_type = 8'h08;
		x.l4_ok = r.le[1];
		return x;
	endfunction : mk
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	initial
	begin
		#20000;
		err_count++;
		end_sim();
	end
	initial
	begin
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		for (logic [7:0] a = 8'h00; a < 8'h34; a += 8'h04)
			rd(a, 32'h00000000, "reset value");
		send(mk(rows[0]), 1'b0);
		wr(acl_entry_pkg::OFS_SRC_ADDR, 32'h0a000001);
		wr(acl_entry_pkg::OFS_SRC_MASK, 32'hffffff00);
		wr(acl_entry_pkg::OFS_DST_ADDR, 32'hc0a80005);
		wr(acl_entry_pkg::OFS_DST_MASK, 32'hffff0000);
		wr(acl_entry_pkg::OFS_CONTROL, 32'h00000031);
		rd(acl_entry_pkg::OFS_SRC_MASK, 32'hffffff00, "source mask");
		$display("reset test done");
		foreach (rows[i])
		begin
			r = rows[i];
			wr(acl_entry_pkg::OFS_PROTOCOL, {16'h0000, r.pro});
			wr(acl_entry_pkg::OFS_HEADER, {24'h000000, r.hdr});
			wr(acl_entry_pkg::OFS_ADDR_MODE, {28'h0000000, r.am});
			wr(acl_entry_pkg::OFS_ICMP, {8'h00, r.icmp});
			send(mk(r), r.le[0]);
		end
		rd(acl_entry_pkg::OFS_PROTOCOL, {16'h0000, rows[38].pro}, "protocol readback");
		rd(acl_entry_pkg::OFS_HIT_COUNT, 32'h00000013, "hit count");
		rd(acl_entry_pkg::OFS_MISS_COUNT, 32'h00000015, "miss count");
		rd(acl_entry_pkg::OFS_STATUS, 32'h00000002, "status");
		$display("table test done");
		wr(acl_entry_pkg::OFS_CONTROL, 32'h00000021);
		send(mk(rows[38]), 1'b1);
		wr(acl_entry_pkg::OFS_CONTROL, 32'h00000031);
		f = mk(rows[37]);
		f.is_ipv4 = 1'b0;
		send(f, 1'b0);
		$display("frame type test done");
		// Counter clear and a hit in one cycle
		@(posedge clk_sys);
		req <= 1'b1;
		rf <= mk(rows[37]);
		@(posedge clk_sys);
		req <= 1'b0;
		rq <= '{acl_entry_pkg::OFS_HIT_COUNT, 32'h00000000, 1'b1, 1'b0};
		@(posedge clk_sys);
		rq.we <= 1'b0;
		rd(acl_entry_pkg::OFS_HIT_COUNT, 32'h00000001, "count clear with hit");
		$display("counter clear test done");
		@(posedge clk_sys);
		req <= 1'b1;
		rf <= mk(rows[37]);
		@(posedge clk_sys);
		rq <= '{acl_entry_pkg::OFS_HEADER, 32'h00000001, 1'b1, 1'b0};
		@(posedge clk_sys);
		req <= 1'b0;
		rq.we <= 1'b0;
		#1;
		chk("old config hit", 32'h1, {31'h0, hit});
		@(posedge clk_sys);
		#1;
		chk("back to back valid", 32'h1, {31'h0, result_valid});
		chk("new config miss", 32'h1, {31'h0, miss});
		$display("back to back test done");
		// Reset in mid run
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(acl_entry_pkg::OFS_CONTROL, 32'h00000000, "control after reset");
		rd(acl_entry_pkg::OFS_HEADER, 32'h00000000, "header after reset");
		rd(acl_entry_pkg::OFS_HIT_COUNT, 32'h00000000, "hit count after reset");
		send(mk(rows[37]), 1'b0);
		$display("mid reset test done");
		end_sim();
	end
endmodule : tb_ipv4_acl_entry_matcher
